// ===== inc/fault_report_pkg.sv
// Constants for the fault reporting and output reaction registers
package fault_report_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W            = 4;
  localparam int          DATA_W            = 16;
  localparam logic [3:0]  ADDR_REPORT_MASK  = 4'h9;
  localparam logic [3:0]  ADDR_OUT_REACTION = 4'ha;
  localparam logic [15:0] RST_REPORT_MASK   = 16'h8940;
  localparam logic [15:0] RST_OUT_REACTION  = 16'hc008;

  // ****************************************************************
  // Report mask fields
  // ****************************************************************
  localparam int BIT_MASK_SPARE      = 15;
  localparam int BIT_SC_MASK         = 14;
  localparam int BIT_OC_MASK         = 13;
  localparam int BIT_GM_ROUTE_HI     = 12;
  localparam int BIT_GM_ROUTE_LO     = 11;
  localparam int BIT_UV_MASK         = 10;
  localparam int BIT_OV_MASK         = 9;
  localparam int BIT_SW_OT_EN        = 8;
  localparam int BIT_DRV_OT_MASK     = 7;
  localparam int BIT_LINK_EN         = 6;
  localparam int BIT_CFG_CRC_MASK    = 5;
  localparam int BIT_TRIM_CRC_MASK   = 4;
  localparam int BIT_REG_MASK        = 3;
  localparam int BIT_BIST_MASK       = 2;
  localparam int BIT_ILIM_MASK       = 1;
  localparam int BIT_CLK_MASK        = 0;

  localparam logic [1:0] GM_ROUTE_MASKED = 2'h0;
  localparam logic [1:0] GM_ROUTE_ALARM  = 2'h1;
  localparam logic [1:0] GM_ROUTE_WARN   = 2'h2;
  localparam logic [1:0] GM_ROUTE_LIVE   = 2'h3;

  // ****************************************************************
  // Output reaction fields
  // ****************************************************************
  localparam int BIT_OT_WARN_EN      = 15;
  localparam int BIT_REACT_SPARE     = 14;
  localparam int BIT_SC_REACT_LO     = 12;
  localparam int BIT_REG_REACT       = 11;
  localparam int BIT_REACT_RESERVED  = 10;
  localparam int BIT_OC_REACT_LO     = 8;
  localparam int BIT_SW_OT_REACT_LO  = 6;
  localparam int BIT_REACT_SPARE2_LO = 4;
  localparam int BIT_GM_REACT_LO     = 2;
  localparam int BIT_LINK_REACT_LO   = 0;

  // Bits that do not start a checksum evaluation when written
  localparam logic [15:0] MASK_SPARE_BITS  = 16'h8000;
  localparam logic [15:0] REACT_SPARE_BITS = 16'h4030;

  typedef enum logic [1:0] {
    REACT_PULL_LOW  = 2'h0,
    REACT_PULL_HIGH = 2'h1,
    REACT_HIZ       = 2'h2,
    REACT_NONE      = 2'h3
  } reaction_t;

  // ****************************************************************
  // Fault detector inputs
  // ****************************************************************
  localparam int NUM_FAULTS = 13;
  localparam int F_SC       = 0;
  localparam int F_OC       = 1;
  localparam int F_GM       = 2;
  localparam int F_UV       = 3;
  localparam int F_OV       = 4;
  localparam int F_SW_OT    = 5;
  localparam int F_DRV_OT   = 6;
  localparam int F_LINK     = 7;
  localparam int F_CFG_CRC  = 8;
  localparam int F_TRIM_CRC = 9;
  localparam int F_REG      = 10;
  localparam int F_BIST     = 11;
  localparam int F_ILIM     = 12;

endpackage

// ===== rtl/fault_report_routing.sv
// Fault reporting masks, alarm/warning routing and output stage reaction select
`timescale 1ns/1ps
//
// Function
// - Mask bit 15 is spare storage; writing it alone starts no checksum evaluation.
// - Bit 14 zero reports short-circuit on alarm; one masks it.
// - Bit 13 zero reports overcurrent on alarm; one masks it.
// - Bits 12-11 route gate monitor: mask, alarm, warning, or live gate state.
// - Bit 10 zero reports secondary undervoltage faults on alarm; one masks.
// - Bit 9 zero reports secondary overvoltage faults on alarm; one masks.
// - Bit 8 one reports switch overtemperature on alarm; zero masks it.
// - Bit 7 masks driver overtemperature on alarm; shutdown happens regardless.
// - Bit 6 one reports cross-barrier link fault on alarm; zero masks.
// - Bit 5 zero reports configuration checksum fault on alarm; one masks.
// - Bit 4 zero reports trim checksum fault on fault outputs; one masks.
// - Bit 3 zero reports internal regulator fault on alarm; one masks.
// - Bit 2 zero reports self-test failure on alarm and warning; one masks.
// - Bit 1 zero reports regulator current-limit fault on alarm; one masks.
// - Bit 0 zero reports clock monitor fault on alarm; one masks.
// - Short-circuit reaction field: pull low, pull high, reserved, no action.
// - Gate monitor reaction field resets to high impedance; other codes as usual.
// - Writing one to a reserved configuration bit sets the checksum fault flag.
// - Overtemperature warning enable bit, reset one, gates the driver warning.

module fault_report_routing (
  // Clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  resetn,
  // Register access port
  input  wire logic                                  regWrEn,
  input  wire logic                                  regRdEn,
  input  wire logic [fault_report_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [fault_report_pkg::DATA_W-1:0]   regWrData,
  output logic      [fault_report_pkg::DATA_W-1:0]   regRdData,
  // Fault detectors
  input  wire logic [fault_report_pkg::NUM_FAULTS-1:0] faultIn,
  input  wire logic                                  clockMonFault,
  input  wire logic                                  gateVoltageState,
  input  wire logic                                  driverOvertempWarn,
  input  wire logic                                  checksumFlagClear,
  // Fault pins
  output logic                                       alarmOutN,
  output logic                                       warningOutN,
  // Output stage and checksum control
  output fault_report_pkg::reaction_t                gateReaction,
  output logic                                       secShutdown,
  output logic                                       checksumEvalStart,
  output logic                                       configChecksumFaultFlag
);
  import fault_report_pkg::*;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [DATA_W-1:0] faultReportMask_ff;
  logic [DATA_W-1:0] faultOutputReaction_ff;
  logic              wrMask;
  logic              wrReact;

  assign wrMask  = regWrEn && (regAddr == ADDR_REPORT_MASK);
  assign wrReact = regWrEn && (regAddr == ADDR_OUT_REACTION);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      faultReportMask_ff     <= RST_REPORT_MASK;
      faultOutputReaction_ff <= RST_OUT_REACTION;
    end else begin
      if (wrMask) begin
        faultReportMask_ff <= regWrData;
      end
      if (wrReact) begin
        // Reserved bit is not stored
        faultOutputReaction_ff <= regWrData & ~(16'h0001 << BIT_REACT_RESERVED);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      regRdData <= 16'h0000;
    end else if (regRdEn) begin
      case (regAddr)
        ADDR_REPORT_MASK:  regRdData <= faultReportMask_ff;
        ADDR_OUT_REACTION: regRdData <= faultOutputReaction_ff;
        default:           regRdData <= 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // Checksum evaluation and checksum fault flag
  // ****************************************************************
  logic nxt_checksumEvalStart;

  // Only a change of a functional bit asks for a new evaluation
  assign nxt_checksumEvalStart =
      (wrMask && (((regWrData ^ faultReportMask_ff) & ~MASK_SPARE_BITS) != 16'h0000)) ||
      (wrReact && (((regWrData ^ faultOutputReaction_ff) & ~REACT_SPARE_BITS) != 16'h0000));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      checksumEvalStart <= 1'b0;
    end else begin
      checksumEvalStart <= nxt_checksumEvalStart;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      configChecksumFaultFlag <= 1'b0;
    end else if (wrReact && regWrData[BIT_REACT_RESERVED]) begin
      configChecksumFaultFlag <= 1'b1;
    end else if (checksumFlagClear) begin
      configChecksumFaultFlag <= 1'b0;
    end
  end

  // ****************************************************************
  // Alarm and warning routing
  // ****************************************************************
  logic [1:0] gmRoute;
  logic       alarmAny;
  logic       warnAny;
  logic       cfgCrcFault;

  assign gmRoute     = faultReportMask_ff[BIT_GM_ROUTE_HI:BIT_GM_ROUTE_LO];
  assign cfgCrcFault = faultIn[F_CFG_CRC] || configChecksumFaultFlag;

  always_comb begin
    alarmAny = 1'b0;
    warnAny  = 1'b0;
    if (faultIn[F_SC] && !faultReportMask_ff[BIT_SC_MASK])             alarmAny = 1'b1;
    if (faultIn[F_OC] && !faultReportMask_ff[BIT_OC_MASK])             alarmAny = 1'b1;
    if (faultIn[F_GM] && (gmRoute == GM_ROUTE_ALARM))                  alarmAny = 1'b1;
    if (faultIn[F_GM] && (gmRoute == GM_ROUTE_WARN))                   warnAny  = 1'b1;
    if (gateVoltageState && (gmRoute == GM_ROUTE_LIVE))                warnAny  = 1'b1;
    if (faultIn[F_UV] && !faultReportMask_ff[BIT_UV_MASK])             alarmAny = 1'b1;
    if (faultIn[F_OV] && !faultReportMask_ff[BIT_OV_MASK])             alarmAny = 1'b1;
    if (faultIn[F_SW_OT] && faultReportMask_ff[BIT_SW_OT_EN])          alarmAny = 1'b1;
    if (faultIn[F_DRV_OT] && !faultReportMask_ff[BIT_DRV_OT_MASK])     alarmAny = 1'b1;
    if (faultIn[F_LINK] && faultReportMask_ff[BIT_LINK_EN])            alarmAny = 1'b1;
    if (cfgCrcFault && !faultReportMask_ff[BIT_CFG_CRC_MASK])          alarmAny = 1'b1;
    if (faultIn[F_TRIM_CRC] && !faultReportMask_ff[BIT_TRIM_CRC_MASK]) begin
      alarmAny = 1'b1;
      warnAny  = 1'b1;
    end
    if (faultIn[F_REG] && !faultReportMask_ff[BIT_REG_MASK])           alarmAny = 1'b1;
    if (faultIn[F_BIST] && !faultReportMask_ff[BIT_BIST_MASK]) begin
      alarmAny = 1'b1;
      warnAny  = 1'b1;
    end
    if (faultIn[F_ILIM] && !faultReportMask_ff[BIT_ILIM_MASK])         alarmAny = 1'b1;
    if (clockMonFault && !faultReportMask_ff[BIT_CLK_MASK])            alarmAny = 1'b1;
    if (driverOvertempWarn && faultOutputReaction_ff[BIT_OT_WARN_EN])  warnAny  = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      alarmOutN   <= 1'b1;
      warningOutN <= 1'b1;
    end else begin
      alarmOutN   <= !alarmAny;
      warningOutN <= !warnAny;
    end
  end

  // ****************************************************************
  // Output stage reaction
  // ****************************************************************
  reaction_t nxt_gateReaction;
  logic [1:0] scCode;

  assign scCode = faultOutputReaction_ff[BIT_SC_REACT_LO +: 2];

  always_comb begin
    nxt_gateReaction = REACT_NONE;
    if (faultIn[F_SC]) begin
      // Reserved short-circuit code takes no action
      nxt_gateReaction = (scCode == 2'h2) ? REACT_NONE : reaction_t'(scCode);
    end else if (faultIn[F_OC]) begin
      nxt_gateReaction = reaction_t'(faultOutputReaction_ff[BIT_OC_REACT_LO +: 2]);
    end else if (faultIn[F_SW_OT]) begin
      nxt_gateReaction = reaction_t'(faultOutputReaction_ff[BIT_SW_OT_REACT_LO +: 2]);
    end else if (faultIn[F_GM]) begin
      nxt_gateReaction = reaction_t'(faultOutputReaction_ff[BIT_GM_REACT_LO +: 2]);
    end else if (faultIn[F_LINK]) begin
      nxt_gateReaction = reaction_t'(faultOutputReaction_ff[BIT_LINK_REACT_LO +: 2]);
    end else if (faultIn[F_REG]) begin
      nxt_gateReaction = faultOutputReaction_ff[BIT_REG_REACT] ? REACT_NONE : REACT_PULL_LOW;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      gateReaction <= REACT_NONE;
      secShutdown  <= 1'b0;
    end else begin
      gateReaction <= nxt_gateReaction;
      secShutdown  <= faultIn[F_DRV_OT];
    end
  end

endmodule // fault_report_routing

// ===== test/fault_host_model.sv
// Host side model counting alarm and warning pin assertions
`timescale 1ns/1ps
module fault_host_model (
  // Pins watched
  input wire logic clk,
  input wire logic alarmOutN,
  input wire logic warningOutN,
  // Event counts
  output int       alarmCount,
  output int       warnCount
);
  logic alarmOld_ff = 1'b1;
  logic warnOld_ff = 1'b1;
  initial alarmCount = 0;
  initial warnCount = 0;
  always @(posedge clk) begin
    alarmOld_ff <= alarmOutN;
    warnOld_ff <= warningOutN;
    if (alarmOld_ff === 1'b1 && alarmOutN === 1'b0) alarmCount++;
    if (warnOld_ff === 1'b1 && warningOutN === 1'b0) warnCount++;
  end
endmodule // fault_host_model

// ===== test/fault_report_routing_properties.sv
// Checker for fault pin and checksum flag behaviour
`timescale 1ns/1ps
module fault_report_routing_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Register writes
  input wire logic        regWrEn,
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWrData,
  // Faults
  input wire logic [12:0] faultIn,
  input wire logic        clockMonFault,
  input wire logic        checksumFlagClear,
  // Outputs watched
  input wire logic        alarmOutN,
  input wire logic        secShutdown,
  input wire logic        checksumEvalStart,
  input wire logic        configChecksumFaultFlag
);
  import fault_report_pkg::*;
  logic [15:0] mask_ff;
  logic        quiet;
  assign quiet = !clockMonFault && !configChecksumFaultFlag;
  // Shadow of the mask register
  always_ff @(posedge clk) begin
    if (!resetn) mask_ff <= RST_REPORT_MASK;
    else if (regWrEn && regAddr == ADDR_REPORT_MASK) mask_ff <= regWrData;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_reset_pins_idle: assert property ($rose(resetn) |-> alarmOutN && !secShutdown)
    else $error("pins not idle after reset");
  a_quiet_alarm_high: assert property (faultIn == 13'h0 && quiet |=> alarmOutN)
    else $error("alarm low with no fault");
  a_sc_fault_shown: assert property (!mask_ff[14] && faultIn[F_SC] |=> !alarmOutN)
    else $error("short circuit not on alarm");
  a_oc_fault_hidden: assert property (mask_ff[13] && faultIn == 13'h2 && quiet |=> alarmOutN)
    else $error("masked overcurrent on alarm");
  a_sw_ot_shown: assert property (mask_ff[8] && faultIn[F_SW_OT] |=> !alarmOutN)
    else $error("switch overtemp not on alarm");
  a_shutdown_follows: assert property (1'b1 |=> secShutdown == $past(faultIn[F_DRV_OT]))
    else $error("shutdown does not follow driver overtemp");
  a_flag_set_write: assert property (regWrEn && regAddr == ADDR_OUT_REACTION
    && regWrData[BIT_REACT_RESERVED] |=> configChecksumFaultFlag)
    else $error("reserved write did not set flag");
  a_flag_stays_set: assert property (configChecksumFaultFlag && !checksumFlagClear
    |=> configChecksumFaultFlag)
    else $error("flag dropped without clear");
  a_spare_no_eval: assert property (regWrEn && regAddr == ADDR_REPORT_MASK
    && regWrData == (mask_ff ^ MASK_SPARE_BITS) |=> !checksumEvalStart)
    else $error("spare write started evaluation");
endmodule // fault_report_routing_properties
bind fault_report_routing fault_report_routing_properties chk (.clk, .resetn, .regWrEn,
  .regAddr, .regWrData, .faultIn, .clockMonFault, .checksumFlagClear, .alarmOutN,
  .secShutdown, .checksumEvalStart, .configChecksumFaultFlag);

// ===== test/fault_report_routing_tb.sv
// Directed testbench for fault report routing
`timescale 1ns/1ps
module fault_report_routing_tb;
  import fault_report_pkg::*;
  logic        clk = 1'b0, resetn = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0, regRdData;
  logic [12:0] faultIn = 13'h0;
  logic        clockMonFault = 1'b0, gateVoltageState = 1'b0, driverOvertempWarn = 1'b0;
  logic        checksumFlagClear = 1'b0, alarmOutN, warningOutN, secShutdown;
  logic        checksumEvalStart, configChecksumFaultFlag;
  reaction_t   gateReaction;
  int          badCount = 0, compares = 0, cycles = 0, alarmCount, warnCount;
  always #5 clk = ~clk;
  fault_report_routing dut (.clk, .resetn, .regWrEn, .regRdEn, .regAddr, .regWrData,
    .regRdData, .faultIn, .clockMonFault, .gateVoltageState, .driverOvertempWarn,
    .checksumFlagClear, .alarmOutN, .warningOutN, .gateReaction, .secShutdown,
    .checksumEvalStart, .configChecksumFaultFlag);
  fault_host_model host (.clk, .alarmOutN, .warningOutN, .alarmCount, .warnCount);
  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    step;
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    step;
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    step;
    regRdEn = 1'b1;
    regAddr = a;
    step;
    regRdEn = 1'b0;
    chk(regRdData, exp);
  endtask
  task automatic pin(input logic [13:0] f, input logic a, input logic w);
    {clockMonFault, faultIn} = f;
    step;
    chk(alarmOutN, a);
    chk(warningOutN, w);
  endtask
  task automatic stopTest;
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      badCount++;
      stopTest;
    end
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk);
    #1;
    resetn = 1'b1;
    rd(ADDR_REPORT_MASK, 16'h8940);
    rd(ADDR_OUT_REACTION, 16'hc008);
    rd(4'h3, 16'h0000);
    pin(14'h0004, 1'b0, 1'b1);
    chk(gateReaction, REACT_HIZ);
    $display("test reset done");
    for (int k = 0; k < 28; k++) begin
      if (k % 14 == 0) wr(ADDR_REPORT_MASK, (k > 0) ? 16'h66bf : 16'h0940);
      pin(14'h1 << (k % 14), k > 13, k > 13 || !(k == F_BIST || k == F_TRIM_CRC));
      chk(secShutdown, k % 14 == F_DRV_OT);
    end
    $display("test masks done");
    wr(ADDR_REPORT_MASK, 16'h1140);
    pin(14'h0004, 1'b1, 1'b0);
    wr(ADDR_REPORT_MASK, 16'h1940);
    pin(14'h0000, 1'b1, 1'b1);
    gateVoltageState = 1'b1;
    pin(14'h0000, 1'b1, 1'b0);
    $display("test gate route done");
    wr(ADDR_REPORT_MASK, 16'h0940);
    // Clear coincides with the reserved write, the set must win
    checksumFlagClear = 1'b1;
    wr(ADDR_OUT_REACTION, 16'hc408);
    checksumFlagClear = 1'b0;
    chk(configChecksumFaultFlag, 1'b1);
    rd(ADDR_OUT_REACTION, 16'hc008);
    pin(14'h0000, 1'b0, 1'b1);
    checksumFlagClear = 1'b1;
    step;
    checksumFlagClear = 1'b0;
    pin(14'h0000, 1'b1, 1'b1);
    wr(ADDR_REPORT_MASK, 16'h8940);
    chk(checksumEvalStart, 1'b0);
    wr(ADDR_REPORT_MASK, 16'h8941);
    chk(checksumEvalStart, 1'b1);
    $display("test checksum done");
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_OUT_REACTION, 16'(16'hc008 | (c << 12)));
      pin(14'h0001, 1'b0, 1'b1);
      chk(gateReaction, (c == 2) ? 2'h3 : c[1:0]);
    end
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_OUT_REACTION, 16'(16'hc000 | (c << 2)));
      pin(14'h0004, 1'b0, 1'b1);
      chk(gateReaction, c[1:0]);
    end
    $display("test reaction done");
    driverOvertempWarn = 1'b1;
    pin(14'h0000, 1'b1, 1'b0);
    wr(ADDR_OUT_REACTION, 16'h4008);
    pin(14'h0000, 1'b1, 1'b1);
    chk(alarmCount > 0 && warnCount > 0, 1'b1);
    $display("test warning done");
    stopTest;
  end
endmodule // fault_report_routing_tb
